// file: verilog/l2iac_pkg.sv
/*
 level 2 interrupt address capture: shared constants and carriers.
 assumes a single 10 MHz clock; all users reference names as l2iac_pkg::name.
*/
`default_nettype none
package l2iac_pkg;
	// counter group code: bit3 = a/b/c, bit2 = a or d, bit1 = b or e, bit0 = c or f
	localparam logic [1:0] USL_96  = 2'h0;
	localparam logic [1:0] USL_8   = 2'h1;
	localparam logic [1:0] USL_48  = 2'h2;
	localparam logic [1:0] USL_16  = 2'h3;
	localparam logic [2:0] GRP_A   = 3'h2;
	localparam logic [2:0] GRP_B   = 3'h3;
	localparam logic [2:0] GRP_C   = 3'h4;
	localparam logic [2:0] GRP_D   = 3'h5;
	localparam logic [2:0] GRP_E   = 3'h6;
	localparam logic [2:0] GRP_F   = 3'h7;
	localparam int         NUM_PRI = 4;
	localparam int         ADR_W   = 9;      // positions 0.6 .. 1.6
	localparam int         IN_W    = 12;     // in data bus 0.4 .. 1.7
	localparam logic [ADR_W-1:0] ADR_RST = 9'h000;
	localparam logic [IN_W-1:0]  VEC_FLAG = 12'h800; // forced 1 at 0.4
	// attachment base phase enable: one pulse each PHASE_DIV+1 (8) clocks
	localparam logic [2:0] PHASE_DIV = 3'h7;

	// capture request from the scanner side
	typedef struct packed {
		logic [1:0] scan_id;    // goes to 0.6/0.7
		logic [3:0] grp;        // counter group code
		logic [3:0] low;        // counter 8,4,2,1
		logic [1:0] usl;        // upper scan limit
		logic [1:0] pri;        // line_control_word priority
	} l2iac_req_s;

	// captured address with its priority
	typedef struct packed {
		logic [ADR_W-1:0] adr;
		logic [1:0]       pri;
	} l2iac_entry_s;
endpackage : l2iac_pkg
`default_nettype wire

// file: verilog/l2iac_addr_map.sv
/*
 rewrites a scan counter value into a line_group_board address.
 purely combinational; assumes inputs are stable for the capture cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module l2iac_addr_map
(
	input  wire logic [3:0]  grp,
	input  wire logic [3:0]  low,
	input  wire logic [1:0]  usl,
	input  wire logic [1:0]  scan_id,
	output logic      [8:0]  adr
);
	logic [2:0] sel;
	logic [3:0] lo;

	// group select and low bits per upper scan limit
	always_comb
	begin
		sel = l2iac_pkg::GRP_A;
		lo  = low;
		unique case (usl)
			l2iac_pkg::USL_96:
			begin
				sel = grp[2] ? (grp[3] ? l2iac_pkg::GRP_A : l2iac_pkg::GRP_D) :
				      grp[1] ? (grp[3] ? l2iac_pkg::GRP_B : l2iac_pkg::GRP_E) :
				               (grp[3] ? l2iac_pkg::GRP_C : l2iac_pkg::GRP_F);
			end
			l2iac_pkg::USL_48:
			begin
				sel = grp[2] ? l2iac_pkg::GRP_A :
				      grp[1] ? l2iac_pkg::GRP_B : l2iac_pkg::GRP_C;
			end
			l2iac_pkg::USL_16:
				sel = l2iac_pkg::GRP_A;
			l2iac_pkg::USL_8:
			begin
				sel   = l2iac_pkg::GRP_A;
				lo[3] = 1'b0;
				lo[0] = low[3];         // odd/even from 8 bit per chart
			end
		endcase
	end

	// positions 0.6 0.7 1.0 1.1 1.2 1.3 1.4 1.5 1.6
	assign adr = {scan_id, sel, lo};
endmodule : l2iac_addr_map
`default_nettype wire

// file: verilog/l2iac_core.sv
/*
 level 2 interrupt address capture: priority registers, pre-buffer,
 interrupt_address_buffer and the inbound vector read.
 assumes the line_scanner request and the central_processor strobes are
 synchronous to sys_clk and that each strobe is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module l2iac_core
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire l2iac_pkg::l2iac_req_s req,
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire logic                  bid_accept,
	input  wire logic                  vec_read,
	output logic [3:0]                 pri_avail,
	output logic                       bid_l2,
	output logic [11:0]                in_data,
	output logic                       in_data_valid
);
	logic [2:0]              div;
	logic [2:0]              next_div;
	logic                    phase;
	logic [8:0]              map_adr;
	logic [8:0]              pri_reg [4];
	logic [8:0]              next_pri_reg [4];
	logic [3:0]              occ;
	logic [3:0]              next_occ;
	l2iac_pkg::l2iac_entry_s pre;
	l2iac_pkg::l2iac_entry_s next_pre;
	l2iac_pkg::l2iac_entry_s buf_q;
	l2iac_pkg::l2iac_entry_s next_buf_q;
	logic                    rd_l, rd_c2, rd_c3;
	logic                    next_rd_l, next_rd_c2, next_rd_c3;
	logic [11:0]             next_in_data;
	logic                    next_in_valid;
	logic                    top_hit;
	logic [1:0]              top_pri;

	l2iac_addr_map u_map
	(
		.grp     (req.grp),
		.low     (req.low),
		.usl     (req.usl),
		.scan_id (req.scan_id),
		.adr     (map_adr)
	);

	// attachment base phase divider
	always_comb
	begin
		next_div = (div == l2iac_pkg::PHASE_DIV) ? 3'h0 : div + 3'h1;
	end
	assign phase = (div == l2iac_pkg::PHASE_DIV);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			div <= 3'h0;
		else
			div <= next_div;
	end

	// highest occupied priority
	always_comb
	begin
		top_hit = |occ;
		top_pri = occ[3] ? 2'h3 : occ[2] ? 2'h2 : occ[1] ? 2'h1 : 2'h0;
	end

	assign pri_avail = ~occ;
	assign req_ready = phase & ~occ[req.pri];
	assign bid_l2    = |occ;

	// capture, select, accept and read sequence
	always_comb
	begin
		for (int i = 0; i < l2iac_pkg::NUM_PRI; i++)
			next_pri_reg[i] = pri_reg[i];
		next_occ      = occ;
		next_pre      = pre;
		next_buf_q    = buf_q;
		next_rd_l     = rd_l;
		next_rd_c2    = rd_c2;
		next_rd_c3    = rd_c3;
		next_in_data  = in_data;
		next_in_valid = 1'b0;
		if (top_hit)
		begin
			next_pre.adr = pri_reg[top_pri];
			next_pre.pri = top_pri;
		end
		if (bid_accept && top_hit)
			next_buf_q = pre;
		// address sits at 0.6..1.6, one above the unused 1.7 position
		if (vec_read)
		begin
			next_in_data  = l2iac_pkg::VEC_FLAG | {2'h0, buf_q.adr, 1'b0};
			next_in_valid = 1'b1;
			next_rd_l     = 1'b1;
		end
		if (phase)
		begin
			next_rd_c2 = rd_l;
			next_rd_c3 = rd_c2;
			if (rd_c3)
			begin
				next_occ[buf_q.pri] = 1'b0;
				next_rd_l  = 1'b0;
				next_rd_c2 = 1'b0;
				next_rd_c3 = 1'b0;
			end
		end
		// capture last so a set beats a same-cycle free
		if (req_valid && req_ready)
		begin
			next_pri_reg[req.pri] = map_adr;
			next_occ[req.pri]     = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < l2iac_pkg::NUM_PRI; i++)
				pri_reg[i] <= l2iac_pkg::ADR_RST;
			occ           <= 4'h0;
			pre           <= '0;
			buf_q         <= '0;
			rd_l          <= 1'b0;
			rd_c2         <= 1'b0;
			rd_c3         <= 1'b0;
			in_data       <= 12'h000;
			in_data_valid <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < l2iac_pkg::NUM_PRI; i++)
				pri_reg[i] <= next_pri_reg[i];
			occ           <= next_occ;
			pre           <= next_pre;
			buf_q         <= next_buf_q;
			rd_l          <= next_rd_l;
			rd_c2         <= next_rd_c2;
			rd_c3         <= next_rd_c3;
			in_data       <= next_in_data;
			in_data_valid <= next_in_valid;
		end
	end

	// bid only drops when a read sequence frees the last entry
	property p_bid;
		@(posedge sys_clk) disable iff (rst) $fell(bid_l2) |-> $past(rd_c3) && $past(phase);
	endproperty
	a_bid: assert property (p_bid) else $error("bid not tied to occupancy");

	// vector read returns buffer address with flag next cycle
	property p_vec;
		@(posedge sys_clk) disable iff (rst) vec_read |=> in_data_valid && in_data[11] && !in_data[10] && !in_data[0] &&
			in_data[9:1] == $past(buf_q.adr);
	endproperty
	a_vec: assert property (p_vec) else $error("vector read data wrong");

	// occupancy only rises on a phase
	property p_phase;
		@(posedge sys_clk) disable iff (rst) (occ & ~$past(occ)) != 4'h0 |-> $past(phase);
	endproperty
	a_phase: assert property (p_phase) else $error("occupied set off phase");

	// buffer only changes on acceptance
	property p_acc;
		@(posedge sys_clk) disable iff (rst) buf_q != $past(buf_q) |-> $past(bid_accept);
	endproperty
	a_acc: assert property (p_acc) else $error("buffer changed without accept");

	// read sequence frees a priority within bounded time
	property p_free;
		@(posedge sys_clk) disable iff (rst) vec_read ##1 !vec_read[*8] |-> ##[0:20] !rd_l;
	endproperty
	a_free: assert property (p_free) else $error("read sequence stuck");

	// pre-buffer tracks highest occupied entry
	property p_pre;
		@(posedge sys_clk) disable iff (rst) top_hit |=> pre.pri == $past(top_pri);
	endproperty
	a_pre: assert property (p_pre) else $error("pre-buffer priority wrong");

	// capture stores the mapped address
	property p_cap;
		@(posedge sys_clk) disable iff (rst) (req_valid && req_ready) |=> pri_reg[$past(req.pri)] == $past(map_adr);
	endproperty
	a_cap: assert property (p_cap) else $error("capture address wrong");

	// limit 16 forces group a
	property p_usl16;
		@(posedge sys_clk) disable iff (rst) req.usl == 2'h3 |-> map_adr[6:4] == 3'h2;
	endproperty
	a_usl16: assert property (p_usl16) else $error("group not forced");

	// read answer only follows a read strobe
	property p_valid;
		@(posedge sys_clk) disable iff (rst) in_data_valid |-> $past(vec_read);
	endproperty
	a_valid: assert property (p_valid) else $error("read answer without strobe");

	// priority 3 held for two cycles owns the pre-buffer
	property p_rank;
		@(posedge sys_clk) disable iff (rst) occ[3] && $past(occ[3]) |-> pre.pri == 2'h3;
	endproperty
	a_rank: assert property (p_rank) else $error("pre-buffer not highest priority");

	// last latch of the read sequence frees the buffered priority
	property p_release;
		@(posedge sys_clk) disable iff (rst) rd_c3 && phase && !(req_valid && req_ready && req.pri == buf_q.pri) |=>
			!occ[$past(buf_q.pri)];
	endproperty
	a_release: assert property (p_release) else $error("buffered priority not freed");
endmodule : l2iac_core
`default_nettype wire

// file: dv/l2iac_cpu_model.sv
/*
 processor model: accepts the level 2 bid, then reads the vector.
 assumes the bench drives stall; strobes change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module l2iac_cpu_model
(
	input  wire logic sys_clk,
	input  wire logic stall,
	input  wire logic bid_l2,
	output logic      bid_accept,
	output logic      vec_read
);
	// accept, read, then wait out the freeing
	initial
	begin
		bid_accept = 1'b0;
		vec_read = 1'b0;
		forever
		begin
			@(negedge sys_clk);
			if (bid_l2 === 1'b1 && stall === 1'b0)
			begin
				repeat ($urandom_range(5, 2)) @(negedge sys_clk);
				bid_accept = 1'b1;
				@(negedge sys_clk);
				bid_accept = 1'b0;
				vec_read = 1'b1;
				@(negedge sys_clk);
				vec_read = 1'b0;
				repeat (30) @(negedge sys_clk);
			end
		end
	end
endmodule : l2iac_cpu_model
`default_nettype wire

// file: dv/l2iac_core_bench.sv
/*
 self-checking bench for l2iac_core: scanner stimulus, vector checks.
 assumes l2iac_cpu_model answers the bid; one 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module l2iac_core_bench;
	logic                  sys_clk;
	logic                  rst;
	l2iac_pkg::l2iac_req_s req;
	logic                  req_valid;
	logic                  req_ready;
	logic                  bid_accept;
	logic                  vec_read;
	logic [3:0]            pri_avail;
	logic                  bid_l2;
	logic [11:0]           in_data;
	logic                  in_data_valid;
	logic                  stall;
	logic                  rd_d = 1'b0;
	logic [11:0]           exp_v[4];
	logic [11:0]           exp_q[$];
	int                    ucnt = 0;
	int                    error_cnt = 0;
	int                    tests_run = 0;

	l2iac_core l2iac_core_inst
	(
		.sys_clk       (sys_clk),
		.rst           (rst),
		.req           (req),
		.req_valid     (req_valid),
		.req_ready     (req_ready),
		.bid_accept    (bid_accept),
		.vec_read      (vec_read),
		.pri_avail     (pri_avail),
		.bid_l2        (bid_l2),
		.in_data       (in_data),
		.in_data_valid (in_data_valid)
	);

	l2iac_cpu_model l2iac_cpu_model_inst
	(
		.sys_clk    (sys_clk),
		.stall      (stall),
		.bid_l2     (bid_l2),
		.bid_accept (bid_accept),
		.vec_read   (vec_read)
	);

	// expected vector from a scanner request
	function automatic logic [11:0] vec_of(input l2iac_pkg::l2iac_req_s r);
		logic [2:0] g;
		logic [3:0] l;
		g = r.grp[2] ? l2iac_pkg::GRP_A : r.grp[1] ? l2iac_pkg::GRP_B : l2iac_pkg::GRP_C;
		l = r.low;
		if (!r.grp[3] && r.usl == l2iac_pkg::USL_96) g = g + 3'h3;
		if (r.usl == l2iac_pkg::USL_16) g = l2iac_pkg::GRP_A;
		if (r.usl == l2iac_pkg::USL_8)
		begin
			g = l2iac_pkg::GRP_A;
			l = {1'b0, r.low[2:1], r.low[3]};
		end
		return {1'b1, 1'b0, r.scan_id, g, l, 1'b0};
	endfunction : vec_of

	task automatic compare(input string what, input logic [11:0] e, input logic [11:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : compare

	// one scanner request, held until taken or lim cycles pass
	task automatic capture(input logic [1:0] p, input int lim, output logic taken);
		l2iac_pkg::l2iac_req_s r;
		int                    n;
		r.scan_id = 2'($urandom);
		r.grp = {1'($urandom), 3'h1 << $urandom_range(2, 0)};
		r.low = 4'($urandom);
		r.usl = 2'(ucnt);
		r.pri = p;
		n = 0;
		taken = 1'b0;
		@(negedge sys_clk);
		req = r;
		req_valid = 1'b1;
		while (!taken && n < lim)
		begin
			#1 taken = (req_ready === 1'b1);
			@(negedge sys_clk);
			n++;
		end
		req_valid = 1'b0;
		if (taken) exp_v[p] = vec_of(r);
		ucnt++;
	endtask : capture

	task automatic conclude();
		$display("errors %0d comparisons %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// clock
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// batches of captures, then the processor drains them
	initial
	begin
		logic       ok;
		logic [3:0] msk;
		rst = 1'b1;
		req = '0;
		req_valid = 1'b0;
		stall = 1'b1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		void'($urandom(40));
		for (int b = 0; b < 10; b++)
		begin
			stall = 1'b1;
			msk = (b == 0) ? 4'hf : 4'($urandom_range(15, 1));
			for (int p = 0; p < 4; p++)
				if (msk[p]) capture(2'(p), 40, ok);
			@(negedge sys_clk);
			compare("pri_avail", {8'h0, ~msk}, {8'h0, pri_avail});
			compare("bid_l2", 12'h1, {11'h0, bid_l2});
			if (msk[3]) capture(2'h3, 20, ok);
			if (msk[3]) compare("refused", 12'h0, {11'h0, ok});
			for (int p = 3; p >= 0; p--)
				if (msk[p]) exp_q.push_back(exp_v[p]);
			stall = 1'b0;
			for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(negedge sys_clk);
			repeat (32) @(negedge sys_clk);
			compare("pri_avail", 12'hf, {8'h0, pri_avail});
			compare("bid_l2", 12'h0, {11'h0, bid_l2});
		end
		conclude();
	end

	// read strobe as the design takes it
	always @(posedge sys_clk)
		rd_d <= vec_read;

	// oldest expected vector against each read answer, mid-cycle
	always @(negedge sys_clk)
	begin
		if (rst === 1'b0) compare("in_data_valid", {11'h0, rd_d}, {11'h0, in_data_valid});
		if (in_data_valid === 1'b1)
			compare("in_data", (exp_q.size() > 0) ? exp_q.pop_front() : 12'hx, in_data);
	end

	// hang guard
	initial
	begin
		#1000000;
		error_cnt++;
		conclude();
	end
endmodule : l2iac_core_bench
`default_nettype wire
